// File: rtl/cct_core.sv
/*
 * cct_core: bit timing, mode control and command/status registers of a can core.
 * Assumes a synchronous register port (cs, we, byte strobes, 16-bit data)
 * and bus/error events supplied by the protocol engine around it.
 */
`timescale 1ns/1ps
// Function
// - The system clock period is two oscillator clocks times prescaler plus one.
// - The bus is sampled once per bit with sampling bit 0 and three times with 1.
// - Each bit starts with a one-clock sync segment then segment one of field plus one clocks.
// - Segment two lasts its field plus one system clocks.
// - Resync on relevant edges shortens or lengthens a bit by at most jump width plus one clocks.
// - Bit timing fields sit at 15, 14:12, 11:8, 7:6, 5:0, written only in reset mode, word only.
// - After hardware reset the core is in reset mode with reset request set.
// - Software configures in reset mode and clearing reset request enters operation mode.
// - Underflow, bus-off, hardware reset or test mode set reset request again.
// - Command bits sit at 7,6,5,3,2,0, reset 01h, hardware may set bit 0.
// - Receive polarity selects inverted input at 1 and changes only in reset mode.
// - Self test drops the need for acknowledge and listen only selects listen mode.
// - Output type bit chooses push-pull at 0 and open-drain at 1.
// - With sleep enable set the transport logic idles when no transport interrupt is raised.
// - Status is read-only, resets to 00h, bits 7 to 2 kept by hardware.
// - Sleep ready is set only with no bus activity and no pending interrupt.
module cct_core import cct_pkg::*; #(
	parameter int PRESC_W = 6,
	parameter int SEG1_W  = 4,
	parameter int SEG2_W  = 3,
	parameter int SJW_W   = 2
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// register port
	input  wire logic        reg_cs,
	input  wire logic        reg_we,
	input  wire logic [9:0]  reg_addr,
	input  wire logic [1:0]  reg_byte_en,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	// protocol engine events and levels
	input  wire logic        tx_buffer_underflow,
	input  wire logic        bus_off,
	input  wire logic        test_mode,
	input  wire logic        error_passive,
	input  wire logic        error_warning,
	input  wire logic        transmit_status,
	input  wire logic        receive_status,
	input  wire logic        core_irq_pending,
	input  wire logic        transport_irq,
	// can bus pins
	input  wire logic        can_rx,
	input  wire logic        can_tx_bit,
	output logic             can_tx_o,
	output logic             can_tx_oe,
	// timing and mode outputs
	output logic             operation_mode,
	output logic             sample_strobe,
	output logic             sampled_bit,
	output logic             bit_start,
	output logic             self_test,
	output logic             listen_only,
	output logic             transport_idle
);
	logic [7:0]  command_reg;
	logic [7:0]  status_reg;
	logic [15:0] bit_timing_reg;
	cct_seg_t    seg_reg;
	cct_seg_t    seg_next;
	logic [4:0]  seg_cnt_reg;
	logic [4:0]  seg_cnt_next;
	logic [2:0]  sample_sh_reg;
	logic        rx_prev_reg;
	logic        sampled_reg;
	logic        sample_reg;
	logic        edge_seen_reg;

	// register decode
	wire        in_reset   = command_reg[CCT_CMD_RESET_REQUEST];
	wire        wr         = reg_cs && reg_we;
	wire        hit_cmd    = (reg_addr == CCT_OFF_COMMAND);
	wire        hit_cmd_w  = (reg_addr == CCT_OFF_BIT_TIMING - 10'h002);
	wire        hit_bt     = (reg_addr == CCT_OFF_BIT_TIMING);
	wire        wr_cmd     = wr && (hit_cmd || hit_cmd_w) && reg_byte_en[0];
	wire        wr_bt      = wr && hit_bt && (reg_byte_en == 2'b11) && in_reset;
	wire        hw_set_rr  = tx_buffer_underflow || bus_off || test_mode;

	// bit timing fields
	wire        sample_count_select = bit_timing_reg[CCT_BT_SAMPLE_COUNT];
	wire [SEG2_W-1:0]  phase_segment_two = bit_timing_reg[CCT_BT_SEG2_LSB +: SEG2_W];
	wire [SEG1_W-1:0]  phase_segment_one = bit_timing_reg[CCT_BT_SEG1_LSB +: SEG1_W];
	wire [SJW_W-1:0]   jump_width        = bit_timing_reg[CCT_BT_SJW_LSB +: SJW_W];
	wire [PRESC_W-1:0] clock_prescaler   = bit_timing_reg[CCT_BT_PRESC_LSB +: PRESC_W];

	// command fields
	wire receive_polarity = command_reg[CCT_CMD_RECEIVE_POLARITY];
	wire sleep_enable     = command_reg[CCT_CMD_SLEEP_ENABLE];
	wire tx_output_type   = command_reg[CCT_CMD_TX_OUTPUT_TYPE];

	// command write value; polarity kept while operating
	wire [7:0] cmd_wval  = reg_wdata[7:0] & CCT_CMD_WMASK;
	wire [7:0] cmd_wkeep = in_reset ? cmd_wval
		: {receive_polarity, cmd_wval[6:0]};

	// command register: hardware set of reset request wins over clear
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			command_reg <= CCT_COMMAND_RST;
		end else if (wr_cmd) begin
			command_reg <= cmd_wkeep | {7'h00, hw_set_rr};
		end else if (hw_set_rr) begin
			command_reg[CCT_CMD_RESET_REQUEST] <= 1'b1;
		end
	end

	// bit timing register, word writes in reset mode only
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bit_timing_reg <= CCT_BIT_TIMING_RST;
		end else if (wr_bt) begin
			bit_timing_reg <= reg_wdata;
		end
	end

	// status register, hardware maintained, read only
	wire sleep_ok = !edge_seen_reg && !core_irq_pending && !transport_irq
		&& rx_prev_reg;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			status_reg <= CCT_STATUS_RST;
		end else begin
			status_reg <= {bus_off, error_passive, error_warning, transmit_status,
				receive_status, sleep_ok, 2'b00};
		end
	end

	// read mux; status byte sits high in the command word
	always_comb begin
		reg_rdata = 16'h0000;
		if (reg_cs && !reg_we) begin
			case (reg_addr)
				CCT_OFF_COMMAND:    reg_rdata = {8'h00, command_reg};
				CCT_OFF_STATUS:     reg_rdata = {8'h00, status_reg};
				CCT_OFF_BIT_TIMING: reg_rdata = bit_timing_reg;
				default:            reg_rdata = 16'h0000;
			endcase
			if (reg_addr == CCT_OFF_COMMAND && reg_byte_en == 2'b11) begin
				reg_rdata = {status_reg, command_reg};
			end
		end
	end

	// system clock tick
	wire tick;
	cct_prescaler #(
		.PRESC_W         (PRESC_W)
	) u_presc (
		.clk             (clk),
		.sys_rst         (sys_rst),
		.run             (operation_mode),
		.clock_prescaler (clock_prescaler),
		.tick            (tick)
	);

	// receive input with selectable polarity
	wire rx_in     = can_rx ^ receive_polarity;
	wire rx_edge   = tick && rx_prev_reg && !rx_in; // recessive to dominant
	wire resync_ok = rx_edge && !edge_seen_reg && seg_reg != CCT_SEG_SYNC;

	// segment lengths and jump limit
	wire [4:0] seg1_len = 5'(phase_segment_one) + 5'd1;
	wire [4:0] seg2_len = 5'(phase_segment_two) + 5'd1;
	wire [4:0] sjw_len  = 5'(jump_width) + 5'd1;
	wire [4:0] seg1_ext = (seg_cnt_reg < sjw_len) ? seg_cnt_reg : sjw_len;
	wire [4:0] seg2_rem = seg2_len - seg_cnt_reg;
	wire       seg2_cut = (seg2_rem <= sjw_len);

	// segment sequencer
	always_comb begin
		seg_next     = seg_reg;
		seg_cnt_next = seg_cnt_reg;
		if (tick) begin
			case (seg_reg)
				CCT_SEG_SYNC: begin
					seg_next     = CCT_SEG_ONE;
					seg_cnt_next = 5'd0;
				end
				CCT_SEG_ONE: begin
					if (resync_ok) begin
						// late edge: lengthen segment one
						seg_cnt_next = seg_cnt_reg - seg1_ext + 5'd1;
					end else if (seg_cnt_reg + 5'd1 >= seg1_len) begin
						seg_next     = CCT_SEG_TWO;
						seg_cnt_next = 5'd0;
					end else begin
						seg_cnt_next = seg_cnt_reg + 5'd1;
					end
				end
				CCT_SEG_TWO: begin
					if (resync_ok && seg2_cut) begin
						// early edge: shorten segment two, edge becomes sync
						seg_next     = CCT_SEG_ONE;
						seg_cnt_next = 5'd0;
					end else if (seg_cnt_reg + 5'd1 >= seg2_len) begin
						seg_next     = CCT_SEG_SYNC;
						seg_cnt_next = 5'd0;
					end else begin
						seg_cnt_next = seg_cnt_reg + 5'd1;
					end
				end
				default: begin
					seg_next     = CCT_SEG_SYNC;
					seg_cnt_next = 5'd0;
				end
			endcase
		end
	end

	// segment state flops
	always_ff @(posedge clk) begin
		if (sys_rst || !operation_mode) begin
			seg_reg     <= CCT_SEG_SYNC;
			seg_cnt_reg <= 5'd0;
		end else begin
			seg_reg     <= seg_next;
			seg_cnt_reg <= seg_cnt_next;
		end
	end

	// sample point: last clock of segment one
	wire at_sample = tick && seg_reg == CCT_SEG_ONE && !resync_ok
		&& (seg_cnt_reg + 5'd1 >= seg1_len);
	wire [2:0] shift_in  = {sample_sh_reg[1:0], rx_in};
	wire       majority  = (shift_in[0] & shift_in[1]) | (shift_in[1] & shift_in[2])
		| (shift_in[0] & shift_in[2]);
	wire       bit_value = sample_count_select ? majority : rx_in;

	// sample history, edge tracking, sampled bit
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sample_sh_reg <= 3'b111;
			rx_prev_reg   <= 1'b1;
			sampled_reg   <= 1'b1;
			sample_reg    <= 1'b0;
			edge_seen_reg <= 1'b0;
		end else begin
			if (tick) begin
				sample_sh_reg <= shift_in; // one sample per system clock
				rx_prev_reg   <= rx_in;
			end
			sample_reg <= at_sample;
			if (at_sample) begin
				sampled_reg <= bit_value;
			end
			// one resync per bit
			if (tick && seg_reg == CCT_SEG_SYNC) begin
				edge_seen_reg <= 1'b0;
			end else if (resync_ok || (rx_edge && seg_reg == CCT_SEG_SYNC)) begin
				edge_seen_reg <= 1'b1;
			end
		end
	end

	// transmit pad control
	wire tx_dom = !can_tx_bit && !listen_only; // listen only never drives dominant
	assign can_tx_o  = tx_output_type ? 1'b0 : !tx_dom ? 1'b1 : 1'b0;
	assign can_tx_oe = operation_mode && (tx_output_type ? tx_dom : 1'b1);

	// mode and control outputs
	assign operation_mode = !in_reset;
	assign self_test      = command_reg[CCT_CMD_SELF_TEST];
	assign listen_only    = command_reg[CCT_CMD_LISTEN_ONLY];
	assign transport_idle = sleep_enable && !transport_irq;
	assign sample_strobe  = sample_reg;
	assign sampled_bit    = sampled_reg;
	assign bit_start      = tick && seg_reg == CCT_SEG_SYNC;
endmodule // cct_core

// File: rtl/cct_pkg.sv
/*
 * cct_pkg: shared constants for the can core timing and mode control block.
 * Assumes an 8/16-bit memory-mapped register port with byte or word strobes.
 */
package cct_pkg;
	// register byte offsets within the memory-mapped block
	localparam logic [9:0] CCT_OFF_COMMAND    = 10'h270;
	localparam logic [9:0] CCT_OFF_STATUS     = 10'h271;
	localparam logic [9:0] CCT_OFF_BIT_TIMING = 10'h272;

	// reset values
	localparam logic [7:0]  CCT_COMMAND_RST    = 8'h01;
	localparam logic [7:0]  CCT_STATUS_RST     = 8'h00;
	localparam logic [15:0] CCT_BIT_TIMING_RST = 16'h0000;

	// command register fields
	localparam int CCT_CMD_RESET_REQUEST    = 0;
	localparam int CCT_CMD_TX_OUTPUT_TYPE   = 2;
	localparam int CCT_CMD_SLEEP_ENABLE     = 3;
	localparam int CCT_CMD_LISTEN_ONLY      = 5;
	localparam int CCT_CMD_SELF_TEST        = 6;
	localparam int CCT_CMD_RECEIVE_POLARITY = 7;
	localparam logic [7:0] CCT_CMD_WMASK    = 8'hED;

	// status register fields
	localparam int CCT_STS_SLEEP_READY     = 2;
	localparam int CCT_STS_RECEIVE_STATUS  = 3;
	localparam int CCT_STS_TRANSMIT_STATUS = 4;
	localparam int CCT_STS_ERROR_WARNING   = 5;
	localparam int CCT_STS_ERROR_PASSIVE   = 6;
	localparam int CCT_STS_BUS_STATUS      = 7;

	// bit timing register fields
	localparam int CCT_BT_SAMPLE_COUNT = 15;
	localparam int CCT_BT_SEG2_LSB     = 12;
	localparam int CCT_BT_SEG1_LSB     = 8;
	localparam int CCT_BT_SJW_LSB      = 6;
	localparam int CCT_BT_PRESC_LSB    = 0;

	// oscillator clocks per prescaler unit
	localparam int CCT_PRESC_MULT = 2;

	// bit timing segment states, one-hot
	typedef enum logic [2:0] {
		CCT_SEG_SYNC = 3'b001,
		CCT_SEG_ONE  = 3'b010,
		CCT_SEG_TWO  = 3'b100
	} cct_seg_t;
endpackage

// File: rtl/cct_prescaler.sv
/*
 * cct_prescaler: makes the can system clock tick from the oscillator clock.
 * Assumes clk is the oscillator clock; tick is one clk cycle wide.
 */
`timescale 1ns/1ps
module cct_prescaler import cct_pkg::*; #(
	parameter int PRESC_W = 6
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               sys_rst,
	// control
	input  wire logic               run,
	input  wire logic [PRESC_W-1:0] clock_prescaler,
	// system clock tick
	output logic                    tick
);
	localparam int CNT_W = PRESC_W + 2;

	logic [CNT_W-1:0] count_reg;
	wire  [CNT_W-1:0] period_last;
	wire              wrap;

	// period is 2*(prescaler+1) oscillator clocks
	assign period_last = CNT_W'(CCT_PRESC_MULT * (int'(clock_prescaler) + 1) - 1);
	assign wrap        = (count_reg >= period_last);

	// free count, held clear while not running
	always_ff @(posedge clk) begin
		if (sys_rst || !run || wrap) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_reg + CNT_W'(1);
		end
	end

	assign tick = run && wrap;
endmodule // cct_prescaler

// File: dv/cct_core_asserts.sv
/* cct_core_asserts: port-level checks of cct_core.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
module cct_core_asserts (
	// clock and reset
	input wire logic        clk, sys_rst,
	// register port
	input wire logic        reg_cs, reg_we,
	input wire logic [9:0]  reg_addr,
	input wire logic [1:0]  reg_byte_en,
	input wire logic [15:0] reg_wdata, reg_rdata,
	// events and pins
	input wire logic        tx_buffer_underflow, bus_off, test_mode,
	input wire logic        can_tx_o, can_tx_oe, listen_only,
	input wire logic        operation_mode, sample_strobe, bit_start
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// access decodes
	wire hw     = tx_buffer_underflow || bus_off || test_mode;
	wire wr_cmd = reg_cs && reg_we && reg_addr == 10'h270 && reg_byte_en[0];
	wire wr_bt  = reg_cs && reg_we && reg_addr == 10'h272 && reg_byte_en == 2'b11;
	wire rd_bt  = reg_cs && !reg_we && reg_addr == 10'h272;
	wire rd_cmd = reg_cs && !reg_we && reg_addr == 10'h270;
	// shadow of the bit timing word, taken only from legal writes
	logic [15:0] bt_shadow;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bt_shadow <= 16'h0000;
		end else if (wr_bt && !operation_mode) begin
			bt_shadow <= reg_wdata;
		end
	end
	property p_rst_mode;
		$past(sys_rst) |-> !operation_mode && !can_tx_oe;
	endproperty
	a_rst_mode: assert property (p_rst_mode) else $error("not in reset mode after reset");
	property p_enter_op;
		wr_cmd && !reg_wdata[0] && !hw |=> operation_mode;
	endproperty
	a_enter_op: assert property (p_enter_op) else $error("clear did not enter operation");
	property p_hw_rr;
		hw |=> !operation_mode;
	endproperty
	a_hw_rr: assert property (p_hw_rr) else $error("event did not force reset mode");
	property p_bt_word;
		rd_bt |-> reg_rdata == bt_shadow;
	endproperty
	a_bt_word: assert property (p_bt_word) else $error("bit timing readback wrong");
	property p_rsvd;
		rd_cmd |-> reg_rdata[4] == 1'b0 && reg_rdata[1] == 1'b0 && reg_rdata[9:8] == 2'b00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
	property p_listen;
		listen_only |-> !(can_tx_oe && !can_tx_o);
	endproperty
	a_listen: assert property (p_listen) else $error("dominant drive in listen mode");
	property p_idle_pad;
		!operation_mode |-> !can_tx_oe;
	endproperty
	a_idle_pad: assert property (p_idle_pad) else $error("pad driven in reset mode");
	property p_strobe_gap;
		sample_strobe |=> !sample_strobe [*3];
	endproperty
	a_strobe_gap: assert property (p_strobe_gap) else $error("samples too close");
	property p_bit_gap;
		bit_start |=> !bit_start [*3];
	endproperty
	a_bit_gap: assert property (p_bit_gap) else $error("bits too short");
endmodule // cct_core_asserts

// File: dv/cct_bus_model.sv
/* cct_bus_model: wired-and can bus with one remote node.
   Assumes the bench sets the remote node level; 1 is recessive. */
`timescale 1ns/1ps
module cct_bus_model (
	// remote node and local pad
	input  wire logic node_rec,
	input  wire logic can_tx_o,
	input  wire logic can_tx_oe,
	// resolved bus level, pulled recessive when nobody drives
	output logic      can_rx
);
	// dominant wins over recessive on the shared line
	assign can_rx = node_rec & ~(can_tx_oe & ~can_tx_o);
endmodule // cct_bus_model

// File: dv/can_core_timing_and_mode_control_tb_top.sv
/* can_core_timing_and_mode_control_tb_top: self-checking bench for cct_core.
   Assumes cct_pkg, cct_bus_model and cct_core_asserts are compiled first. */
`timescale 1ns/1ps
module can_core_timing_and_mode_control_tb_top import cct_pkg::*; ;
	logic        clk, sys_rst, reg_cs, reg_we, node_rec, cpend, tirq, can_tx_bit;
	logic [9:0]  reg_addr;
	logic [1:0]  reg_byte_en;
	logic [15:0] reg_wdata, rd, bt, bt_m;
	logic [7:0]  cmd_m, c;
	logic [3:0]  st;
	logic [2:0]  ev;
	logic [31:0] seed;
	wire  [15:0] reg_rdata;
	wire         can_rx, can_tx_o, can_tx_oe, operation_mode, sample_strobe, sampled_bit;
	wire         bit_start, self_test, listen_only, transport_idle;
	int          err_count, n_tests, cyc, n;
	cct_core dut (.clk(clk), .sys_rst(sys_rst), .reg_cs(reg_cs), .reg_we(reg_we), .reg_addr(reg_addr),
		.reg_byte_en(reg_byte_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.tx_buffer_underflow(ev[0]), .bus_off(ev[1]), .test_mode(ev[2]), .error_passive(st[3]),
		.error_warning(st[2]), .transmit_status(st[1]), .receive_status(st[0]),
		.core_irq_pending(cpend), .transport_irq(tirq), .can_rx(can_rx), .can_tx_bit(can_tx_bit),
		.can_tx_o(can_tx_o), .can_tx_oe(can_tx_oe), .operation_mode(operation_mode),
		.sample_strobe(sample_strobe), .sampled_bit(sampled_bit), .bit_start(bit_start),
		.self_test(self_test), .listen_only(listen_only), .transport_idle(transport_idle));
	cct_bus_model bus (.node_rec(node_rec), .can_tx_o(can_tx_o), .can_tx_oe(can_tx_oe), .can_rx(can_rx));
	// clock and hang guard
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_count++;
			end_sim();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	// one register cycle; the model follows writes
	task automatic acc(input logic [9:0] a, input logic w, input logic [1:0] be, input logic [15:0] d);
		@(posedge clk);
		reg_cs <= 1'b1;
		reg_we <= w;
		reg_addr <= a;
		reg_byte_en <= be;
		reg_wdata <= d;
		@(negedge clk);
		rd = reg_rdata;
		@(posedge clk);
		reg_cs <= 1'b0;
		if (w && a == CCT_OFF_BIT_TIMING && be == 2'b11 && cmd_m[0])
			bt_m = d;
		if (w && a == CCT_OFF_COMMAND && be[0])
			cmd_m = (d[7:0] & CCT_CMD_WMASK & {cmd_m[0], 7'h7F}) | (cmd_m & {!cmd_m[0], 7'h00});
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// main sequence
	initial begin
		clk = 0; sys_rst = 1; reg_cs = 0; reg_we = 0; reg_addr = 0; reg_byte_en = 0; reg_wdata = 0;
		ev = 0; st = 0; cpend = 1; tirq = 0; node_rec = 1; can_tx_bit = 1; seed = 32'h07DB6711;
		cmd_m = 8'h01;
		bt_m = 16'h0000;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		acc(CCT_OFF_COMMAND, 0, 2'b11, 0);
		chk(rd, {CCT_STATUS_RST, cmd_m});
		acc(CCT_OFF_BIT_TIMING, 0, 2'b11, 0);
		chk(rd, bt_m);
		acc(10'h000, 0, 2'b11, 0);
		chk(rd, 16'h0000);
		acc(CCT_OFF_COMMAND, 1, 2'b01, 16'hFFFF);
		acc(CCT_OFF_COMMAND, 0, 2'b01, 0);
		chk({8'h00, rd[7:0]}, {8'h00, cmd_m});
		chk(16'({self_test, listen_only, transport_idle}), 16'h0007);
		tirq <= 1'b1;
		@(negedge clk);
		chk(16'(transport_idle), 16'h0000);
		tirq <= 1'b0;
		seed = lfsr(seed);
		st <= seed[3:0];
		cpend <= 1'b0;
		acc(CCT_OFF_STATUS, 1, 2'b10, 16'hFFFF);
		acc(CCT_OFF_COMMAND, 0, 2'b11, 0);
		chk({9'h000, rd[14:8]}, {9'h000, st, 3'b100});
		cpend <= 1'b1;
		acc(CCT_OFF_COMMAND, 0, 2'b11, 0);
		acc(CCT_OFF_COMMAND, 0, 2'b11, 0);
		chk({9'h000, rd[14:8]}, {9'h000, st, 3'b000});
		st <= 4'h0;
		$display("register test done");
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			bt = seed[15:0] & 16'hFFC7;
			acc(CCT_OFF_BIT_TIMING, 1, 2'b11, bt);
			acc(CCT_OFF_BIT_TIMING, 1, 2'b01, ~bt);
			acc(CCT_OFF_BIT_TIMING, 0, 2'b11, 0);
			chk(rd, bt_m);
			c = {i[0], 4'b0000, i[1], 2'b00};
			acc(CCT_OFF_COMMAND, 1, 2'b01, {8'h00, c});
			@(negedge clk);
			chk(16'(operation_mode), 16'h0001);
			chk(16'({can_tx_oe, can_tx_o}), i[1] ? 16'h0000 : 16'h0003);
			@(negedge clk iff bit_start);
			n = 0;
			@(negedge clk iff bit_start);
			do begin
				@(negedge clk);
				n++;
			end while (!bit_start);
			chk(16'(n), 16'(2 * (bt[5:0] + 1) * (3 + bt[11:8] + bt[14:12])));
			node_rec <= seed[20];
			repeat (3) @(negedge clk iff sample_strobe);
			chk(16'(sampled_bit), 16'(seed[20] ^ i[0]));
			node_rec <= 1'b1;
			acc(CCT_OFF_BIT_TIMING, 1, 2'b11, ~bt);
			acc(CCT_OFF_COMMAND, 1, 2'b01, {8'h00, c ^ 8'h80});
			acc(CCT_OFF_BIT_TIMING, 0, 2'b11, 0);
			chk(rd, bt_m);
			acc(CCT_OFF_COMMAND, 0, 2'b01, 0);
			chk({8'h00, rd[7:0]}, {8'h00, cmd_m});
			@(posedge clk);
			ev <= 3'(1 << i);
			@(posedge clk);
			ev <= 3'b000;
			cmd_m[0] = 1'b1;
			acc(CCT_OFF_COMMAND, 0, 2'b01, 0);
			chk({8'h00, rd[7:0]}, {8'h00, cmd_m});
			$display("timing test %0d done", i);
		end
		end_sim();
	end
endmodule // can_core_timing_and_mode_control_tb_top

bind cct_core cct_core_asserts u_chk (.clk, .sys_rst, .reg_cs, .reg_we, .reg_addr, .reg_byte_en, .reg_wdata,
	.reg_rdata, .tx_buffer_underflow, .bus_off, .test_mode, .can_tx_o, .can_tx_oe, .listen_only,
	.operation_mode, .sample_strobe, .bit_start);
